// File: include/irc_params.svh
// Purpose: constants for the interrupt input and reset configuration block
// Assumes: one master clock, CLK_IN, at 10 MHz (period 100 ns)
// Notes:   included by the top module only; the synchroniser gets its values as parameters
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH

`define IRC_CLK_PERIOD_NS   100
`define IRC_PROC_CLK_DIV    2
`define IRC_IRQ_WIDTH       6
`define IRC_HALF_IRQ_WIDTH  3
`define IRC_LANE_WIDTH      2
`define IRC_SYNC_STAGES     2
`define IRC_SYNC_IRQ_RST    3'h7
`define IRC_LANE_RST        2'h3
`define IRC_MRST_SYNC_RST   1'h0
`define IRC_IRQ_PEND_RST    6'h00
`define IRC_CFG_RST         4'hF
`define IRC_CFG_ADDR_BIT    0
`define IRC_CFG_BYTE_BIT    0

`endif

// File: include/irc_pkg.sv
// Purpose: types for the interrupt input and reset configuration block
// Assumes: constants live in irc_params.svh
// Notes:   the option struct is the carrier for all captured mode bits
package irc_pkg;

   // whether shared pins are being read as mode bits or in normal use
   typedef enum logic [0:0] {
      IRC_CFG_SAMPLE = 1'b0,
      IRC_RUN        = 1'b1
   } irc_state_e;

   // captured reset configuration, 1 = pin was high at capture
   typedef struct packed {
      logic       addr_show_cache_bypass_opt;
      logic       msb_first_byte_order_opt;
      logic [1:0] reserved_tie_high_opt;
   } irc_cfg_s;

endpackage : irc_pkg

// File: verilog/irc_sync.sv
// Purpose: multi-bit two-stage synchroniser for asynchronous pins
// Assumes: each bit is an independent level; no word coherency is given
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module irc_sync #(
   parameter int                WIDTH   = 1,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clk_in,   // master clock
   input  wire logic             rst_in,   // async reset, active high
   input  wire logic [WIDTH-1:0] async_in, // pin level
   output logic      [WIDTH-1:0] sync_out  // level after two flops
);

   logic [WIDTH-1:0] meta;

   // two flops; meta is read by sync_out alone to keep metastability contained
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta     <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : irc_sync
`default_nettype wire

// File: verilog/irc_top.sv
// Purpose: interrupt request inputs and reset configuration capture
// Assumes: direct irq inputs come from logic on CLK_IN; all other pins are asynchronous
// Notes:   CLK_IN is the double-rate master clock; one processor cycle is two CLK_IN edges
`timescale 1ns/10ps
`default_nettype none
`include "irc_params.svh"
module irc_top (
   input  wire logic                           CLK_IN,             // double-rate master clock
   input  wire logic                           RST_IN,             // async reset, active high
   input  wire logic                           MASTER_RESET_N_IN,  // master reset pin, active low
   input  wire logic [`IRC_HALF_IRQ_WIDTH-1:0] DIRECT_IRQ_N_IN,    // irq 5..3, pre-synchronised
   input  wire logic [`IRC_HALF_IRQ_WIDTH-1:0] SYNCED_IRQ_N_IN,    // irq 2..0, asynchronous
   input  wire logic [`IRC_LANE_WIDTH-1:0]     HALF_LANE_STROBE_N_IN,   // lane strobe pin level
   input  wire logic [`IRC_LANE_WIDTH-1:0]     BUS_LANE_STROBE_N_IN,    // strobe value from bus unit
   output logic      [`IRC_LANE_WIDTH-1:0]     HALF_LANE_STROBE_N_OUT,  // lane strobe pin drive
   output logic      [`IRC_LANE_WIDTH-1:0]     HALF_LANE_STROBE_OE_OUT, // high while driving
   output logic      [`IRC_IRQ_WIDTH-1:0]      IRQ_PEND_OUT,       // pending vector, active high
   output irc_pkg::irc_cfg_s                   CFG_OPT_OUT,        // captured options
   output logic                                RESET_ACTIVE_OUT,   // master reset seen, synced
   output logic                                SYSCLK_OUT          // processor-rate clock
);

   logic                           mrst_n_sync;
   logic [`IRC_HALF_IRQ_WIDTH-1:0] sirq_n_sync;
   logic [`IRC_LANE_WIDTH-1:0]     lane_n_sync;
   irc_pkg::irc_state_e            state;
   irc_pkg::irc_state_e            next_state;
   irc_pkg::irc_cfg_s              next_cfg;

   // master reset pin is asynchronous, so it is synchronised like the synced irq and lane strobe pins
   irc_sync #(
      .WIDTH   (1),
      .RST_VAL (`IRC_MRST_SYNC_RST)
   ) u_mrst_sync (
      .clk_in   (CLK_IN),
      .rst_in   (RST_IN),
      .async_in (MASTER_RESET_N_IN),
      .sync_out (mrst_n_sync)
   );

   // synced irq inputs may come from any asynchronous source
   irc_sync #(
      .WIDTH   (`IRC_HALF_IRQ_WIDTH),
      .RST_VAL (`IRC_SYNC_IRQ_RST)
   ) u_sirq_sync (
      .clk_in   (CLK_IN),
      .rst_in   (RST_IN),
      .async_in (SYNCED_IRQ_N_IN),
      .sync_out (sirq_n_sync)
   );

   // lane strobe pins read back as straps during reset
   irc_sync #(
      .WIDTH   (`IRC_LANE_WIDTH),
      .RST_VAL (`IRC_LANE_RST)
   ) u_lane_sync (
      .clk_in   (CLK_IN),
      .rst_in   (RST_IN),
      .async_in (HALF_LANE_STROBE_N_IN),
      .sync_out (lane_n_sync)
   );

   // processor clock is half the master clock, so a processor cycle is two edges
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         SYSCLK_OUT <= 1'b0;
      end else begin
         SYSCLK_OUT <= ~SYSCLK_OUT;
      end
   end

   // mode follows the synchronised master reset level
   always_comb begin
      next_state = mrst_n_sync ? irc_pkg::IRC_RUN : irc_pkg::IRC_CFG_SAMPLE;
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state            <= irc_pkg::IRC_CFG_SAMPLE;
         RESET_ACTIVE_OUT <= 1'b1;
      end else begin
         state            <= next_state;
         RESET_ACTIVE_OUT <= ~mrst_n_sync;
      end
   end

   // straps as they stand now; re-taken every cycle in reset, so the last one wins
   always_comb begin
      next_cfg.addr_show_cache_bypass_opt = DIRECT_IRQ_N_IN[`IRC_CFG_ADDR_BIT];
      next_cfg.msb_first_byte_order_opt   = sirq_n_sync[`IRC_CFG_BYTE_BIT];
      next_cfg.reserved_tie_high_opt      = lane_n_sync;
   end

   // capture only in sample mode; frozen in run mode whatever the pins do
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         CFG_OPT_OUT <= `IRC_CFG_RST;
      end else begin
         case (state)
            irc_pkg::IRC_CFG_SAMPLE: begin
               CFG_OPT_OUT <= next_cfg;
            end
            irc_pkg::IRC_RUN: begin
               CFG_OPT_OUT <= CFG_OPT_OUT;
            end
            default: begin
               CFG_OPT_OUT <= CFG_OPT_OUT;
            end
         endcase
      end
   end

   // pending vector; direct bits skip the synchroniser and so lead by two edges
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         IRQ_PEND_OUT <= `IRC_IRQ_PEND_RST;
      end else begin
         case (state)
            irc_pkg::IRC_RUN: begin
               IRQ_PEND_OUT <= ~{DIRECT_IRQ_N_IN, sirq_n_sync};
            end
            default: begin
               IRQ_PEND_OUT <= `IRC_IRQ_PEND_RST;
            end
         endcase
      end
   end

   // lane pins released while they are straps, driven by the bus unit otherwise
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         HALF_LANE_STROBE_N_OUT  <= `IRC_LANE_RST;
         HALF_LANE_STROBE_OE_OUT <= '0;
      end else begin
         case (next_state)
            irc_pkg::IRC_RUN: begin
               HALF_LANE_STROBE_N_OUT  <= BUS_LANE_STROBE_N_IN;
               HALF_LANE_STROBE_OE_OUT <= '1;
            end
            default: begin
               HALF_LANE_STROBE_N_OUT  <= `IRC_LANE_RST;
               HALF_LANE_STROBE_OE_OUT <= '0;
            end
         endcase
      end
   end

   // checks on the behaviour above
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   sequence s_run3;
      (state == irc_pkg::IRC_RUN) [*3];
   endsequence

   sequence s_both_drop;
      (state == irc_pkg::IRC_RUN && $fell(DIRECT_IRQ_N_IN[0]) && $fell(SYNCED_IRQ_N_IN[0]))
      ##1 (state == irc_pkg::IRC_RUN && !DIRECT_IRQ_N_IN[0] && !SYNCED_IRQ_N_IN[0]) [*2];
   endsequence

   a_cfg_capture_addr: assert property (
      state == irc_pkg::IRC_CFG_SAMPLE |=>
         CFG_OPT_OUT.addr_show_cache_bypass_opt == $past(DIRECT_IRQ_N_IN[0]))
      else $error("address-show option not taken from direct irq 3 in reset");

   a_cfg_capture_lane: assert property (
      state == irc_pkg::IRC_CFG_SAMPLE |=>
         CFG_OPT_OUT.reserved_tie_high_opt == $past(lane_n_sync) &&
         CFG_OPT_OUT.msb_first_byte_order_opt == $past(sirq_n_sync[0]))
      else $error("lane or byte-order option not captured in reset");

   a_cfg_hold_run: assert property (
      state == irc_pkg::IRC_RUN |=> $stable(CFG_OPT_OUT))
      else $error("options changed outside reset");

   a_irq_reset_quiet: assert property (
      state == irc_pkg::IRC_CFG_SAMPLE |=> IRQ_PEND_OUT == `IRC_IRQ_PEND_RST)
      else $error("irq pending during reset");

   a_direct_irq_path: assert property (
      state == irc_pkg::IRC_RUN |=> IRQ_PEND_OUT[5:3] == ~$past(DIRECT_IRQ_N_IN))
      else $error("direct irq not one edge from pin");

   a_synced_irq_path: assert property (
      s_run3 |=> IRQ_PEND_OUT[2:0] == ~$past(SYNCED_IRQ_N_IN, 3))
      else $error("synced irq not three edges from pin");

   a_latency_gap: assert property (
      s_both_drop |-> IRQ_PEND_OUT[3] && !IRQ_PEND_OUT[0] |=> IRQ_PEND_OUT[0])
      else $error("direct irq not one processor cycle ahead");

   a_sysclk_rate: assert property (
      $rose(SYSCLK_OUT) |=> $fell(SYSCLK_OUT) ##1 $rose(SYSCLK_OUT))
      else $error("processor clock not half of master clock");

   a_lane_release: assert property (
      !mrst_n_sync |=> !HALF_LANE_STROBE_OE_OUT[0] && !HALF_LANE_STROBE_OE_OUT[1] && RESET_ACTIVE_OUT)
      else $error("lane pins driven during reset");

endmodule : irc_top
`default_nettype wire

// File: tb/irc_partner.sv
// Purpose: far-side model of irq sources and config straps
// Assumes: the bench changes its commands on the falling clock edge
// Notes:   straps are driven only while strap_en_in is high
`timescale 1ns/10ps
`default_nettype none
module irc_partner (
   input  wire logic       strap_en_in,  // drive straps instead of irqs
   input  wire logic [3:0] strap_in,     // addr, byte, lane[1:0]
   input  wire logic [5:0] req_in,       // irq requests, active high
   output logic      [2:0] direct_n_out, // irq 5..3 pins
   output logic      [2:0] synced_n_out, // irq 2..0 pins
   output logic      [1:0] lane_out      // lane strap resistors
);
   // direct pins move only with the falling-edge commands, so they stay clock-aligned
   assign direct_n_out = strap_en_in ? {2'h3, strap_in[3]} : ~req_in[5:3];
   // synced pins are skewed off the edge to look like an unrelated source; skew stays under half a period
   assign #37 synced_n_out = strap_en_in ? {2'h3, strap_in[2]} : ~req_in[2:0];
   // reserved straps are pulled up outside configuration
   assign lane_out = strap_en_in ? strap_in[1:0] : 2'h3;
endmodule : irc_partner
`default_nettype wire

// File: tb/irc_top_tb_top.sv
// Purpose: self-checking bench for irc_top
// Assumes: inputs change on the falling clock edge
// Notes:   the shared lane pin level is resolved here from enable and strap
`timescale 1ns/10ps
`default_nettype none
module irc_top_tb_top;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              mrst_n = 1'b0;
   logic              strap_en = 1'b1;
   logic [3:0]        strap = 4'hF;
   logic [5:0]        req = 6'h00;
   logic [1:0]        bus_lane = 2'h3;
   logic [2:0]        dir_n, syn_n;
   logic [1:0]        lane_strap, lane_pin, lane_out, lane_oe;
   logic [5:0]        pend;
   irc_pkg::irc_cfg_s cfg;
   logic              rst_act, sysclk;
   int                err_total = 0;
   int                cmp_count = 0;

   // 10 MHz master clock
   always #50 clk = ~clk;
   // pin is the strap unless the block drives it
   assign lane_pin = (lane_oe & lane_out) | (~lane_oe & lane_strap);

   irc_partner PRT (.strap_en_in(strap_en), .strap_in(strap), .req_in(req),
      .direct_n_out(dir_n), .synced_n_out(syn_n), .lane_out(lane_strap));
   irc_top DUT (.CLK_IN(clk), .RST_IN(rst), .MASTER_RESET_N_IN(mrst_n), .DIRECT_IRQ_N_IN(dir_n),
      .SYNCED_IRQ_N_IN(syn_n), .HALF_LANE_STROBE_N_IN(lane_pin), .BUS_LANE_STROBE_N_IN(bus_lane),
      .HALF_LANE_STROBE_N_OUT(lane_out), .HALF_LANE_STROBE_OE_OUT(lane_oe), .IRQ_PEND_OUT(pend),
      .CFG_OPT_OUT(cfg), .RESET_ACTIVE_OUT(rst_act), .SYSCLK_OUT(sysclk));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // bounded wait for the synced master reset state
   task automatic wait_act(input logic lvl);
      int n;
      n = 0;
      while (rst_act !== lvl && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(8'(rst_act), 8'(lvl));
   endtask : wait_act

   // early strap value is overwritten; only the final one may stick
   task automatic test_cfg(input logic [3:0] s);
      @(negedge clk);
      mrst_n <= 1'b0;
      strap_en <= 1'b1;
      strap <= ~s;
      wait_act(1'b1);
      repeat (4) @(negedge clk);
      strap <= s;
      repeat (4) @(negedge clk);
      chk(8'(pend), 8'h00);
      chk(8'(lane_oe), 8'h00);
      mrst_n <= 1'b1;
      wait_act(1'b0);
      repeat (2) @(negedge clk);
      strap_en <= 1'b0;
      bus_lane <= ~s[1:0];
      repeat (4) @(negedge clk);
      chk(8'(cfg), 8'(s));
      chk(8'(lane_oe), 8'h03);
      chk(8'(lane_pin), {6'h00, ~s[1:0]});
      $display("test cfg %h done", s);
   endtask : test_cfg

   // direct and synced bit raised together; direct must lead by one processor cycle
   task automatic test_irq();
      int i, n, nd, ns;
      for (i = 0; i < 3; i++) begin
         repeat (4) @(negedge clk);
         nd = 0;
         ns = 0;
         req <= 6'h09 << i;
         for (n = 1; n <= 6; n++) begin
            @(negedge clk);
            if (nd == 0 && pend[i+3] === 1'b1) nd = n;
            if (ns == 0 && pend[i] === 1'b1) ns = n;
         end
         chk(8'(nd), 8'h01);
         chk(8'(ns - nd), 8'h02);
         chk(8'(pend), 8'(6'h09 << i));
         req <= 6'h00;
      end
      repeat (4) @(negedge clk);
      chk(8'(pend), 8'h00);
      $display("test irq done");
   endtask : test_irq

   // processor clock is half the master rate
   task automatic test_clk();
      logic prev;
      int   n;
      for (n = 0; n < 4; n++) begin
         prev = sysclk;
         @(negedge clk);
         chk(8'(sysclk), {7'h00, ~prev});
      end
      $display("test clk done");
   endtask : test_clk

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst <= 1'b0;
      test_cfg(4'h6);
      test_cfg(4'h9);
      test_irq();
      test_clk();
      tally_and_finish();
   end

   // watchdog: tests need under a hundred cycles, allow 5000
   initial begin
      #500000;
      err_total++;
      tally_and_finish();
   end
endmodule : irc_top_tb_top
`default_nettype wire
